// File: rtl/rti_target.sv
/*
  Two-wire target giving register access to the device's control space.
  Assumes the controller makes the serial clock; pins are sampled on
  SYS_CLK through three-flop synchronisers.
*/
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rti_target (
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  rti_link_if.target      LINK,
  input  wire logic [1:0] UPPER_ADDRESS_STRAP,
  input  wire logic [1:0] LOWER_ADDRESS_STRAP,
  output logic            LIMITED_REDRIVE_SELECT,
  output logic            REGISTER_EQ_SOURCE,
  output logic            FLIP_SELECT,
  output logic            PATH_ENABLE,
  output logic [7:0]      LANE1_TX_SHAPING,
  output logic [7:0]      LANE2_TX_SHAPING,
  output logic [7:0]      ADAPTIVE_EQ_CTRL_A,
  output logic [7:0]      ADAPTIVE_EQ_CTRL_B,
  output logic [7:0]      CONNECTOR_RX_EQ,
  output logic [7:0]      SYSTEM_RX_EQ,
  output logic [7:0]      OUTPUT_SWING
);
  // ==========================================================
  // State
  typedef enum logic [2:0] {
    RT_IDLE, RT_ADDR, RT_ADDR_ACK, RT_RX, RT_RX_ACK, RT_TX, RT_TX_ACK, RT_WAIT_STOP
  } rti_tstate_t;

  typedef struct packed {
    rti_tstate_t state;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_q;
    logic        sda_q;
    logic [7:0]  shift;
    logic [3:0]  bits;
    logic        reading;
    logic        got_offset;
    logic        sda_oe;
    logic [7:0]  ptr;
    logic [6:0]  my_addr;
    logic [7:0]  gen_ctrl;
    logic [7:0]  lane1;
    logic [7:0]  lane2;
    logic [7:0]  aeq_a;
    logic [7:0]  aeq_b;
    logic [7:0]  conn_eq;
    logic [7:0]  sys_eq;
    logic [7:0]  swing;
  } rti_tregs_t;

  rti_tregs_t r_ff;
  rti_tregs_t nxt_r;

  // ==========================================================
  // Decoding helpers
  function automatic logic [6:0] strap_addr(input logic [1:0] up, input logic [1:0] lo);
    logic [6:0] base;
    base = rti_pkg::ADDR_BASE_0;
    case (up)
      rti_pkg::STRAP_RES:   base = rti_pkg::ADDR_BASE_R;
      rti_pkg::STRAP_FLOAT: base = rti_pkg::ADDR_BASE_F;
      rti_pkg::STRAP_HIGH:  base = rti_pkg::ADDR_BASE_1;
      default:              base = rti_pkg::ADDR_BASE_0;
    endcase
    return base + {5'h00, lo};
  endfunction : strap_addr

  function automatic logic [7:0] reg_read(input rti_tregs_t s, input logic [7:0] ofs);
    case (ofs)
      rti_pkg::OFS_GENERAL_CONTROL:    reg_read = s.gen_ctrl;
      rti_pkg::OFS_LANE1_TX_SHAPING:   reg_read = s.lane1;
      rti_pkg::OFS_LANE2_TX_SHAPING:   reg_read = s.lane2;
      rti_pkg::OFS_ADAPTIVE_EQ_CTRL_A: reg_read = s.aeq_a;
      rti_pkg::OFS_ADAPTIVE_EQ_CTRL_B: reg_read = s.aeq_b;
      rti_pkg::OFS_CONNECTOR_RX_EQ:    reg_read = s.conn_eq;
      rti_pkg::OFS_SYSTEM_RX_EQ:       reg_read = s.sys_eq;
      rti_pkg::OFS_OUTPUT_SWING_CTRL:  reg_read = s.swing;
      default:                         reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ==========================================================
  // Next-state logic
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // Filtered lines: change only when stages two and three agree
  assign scl_s    = (r_ff.scl_sy[2] == r_ff.scl_sy[1]) ? r_ff.scl_sy[2] : r_ff.scl_q;
  assign sda_s    = (r_ff.sda_sy[2] == r_ff.sda_sy[1]) ? r_ff.sda_sy[2] : r_ff.sda_q;
  assign scl_rise = scl_s & ~r_ff.scl_q;
  assign scl_fall = ~scl_s & r_ff.scl_q;
  assign start_c  = r_ff.scl_q & scl_s & r_ff.sda_q & ~sda_s;
  assign stop_c   = r_ff.scl_q & scl_s & ~r_ff.sda_q & sda_s;

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.scl_sy = {r_ff.scl_sy[1:0], LINK.scl};
    nxt_r.sda_sy = {r_ff.sda_sy[1:0], LINK.sda};
    nxt_r.scl_q  = scl_s;
    nxt_r.sda_q  = sda_s;
    // Straps are only trusted outside transfers
    if (r_ff.state == RT_IDLE) begin
      nxt_r.my_addr = strap_addr(UPPER_ADDRESS_STRAP, LOWER_ADDRESS_STRAP);
    end
    if (stop_c) begin
      nxt_r.state  = RT_IDLE;
      nxt_r.sda_oe = 1'b0;
    end else if (start_c) begin
      // Repeated start keeps the pointer just set by the offset byte
      nxt_r.state  = RT_ADDR;
      nxt_r.bits   = 4'h0;
      nxt_r.sda_oe = 1'b0;
    end else begin
      case (r_ff.state)
        RT_ADDR: begin
          if (scl_rise) begin
            nxt_r.shift = {r_ff.shift[6:0], sda_s};
            nxt_r.bits  = r_ff.bits + 4'h1;
          end
          if (scl_fall && r_ff.bits == 4'h8) begin
            if (r_ff.shift[7:1] == r_ff.my_addr) begin
              nxt_r.sda_oe     = 1'b1;
              nxt_r.reading    = r_ff.shift[0];
              nxt_r.got_offset = 1'b0;
              nxt_r.state      = RT_ADDR_ACK;
            end else begin
              nxt_r.state = RT_WAIT_STOP;
            end
          end
        end
        RT_ADDR_ACK, RT_RX_ACK: begin
          if (scl_fall) begin
            nxt_r.bits = 4'h0;
            if (r_ff.reading) begin
              nxt_r.shift  = reg_read(r_ff, r_ff.ptr);
              nxt_r.sda_oe = ~nxt_r.shift[7];
              nxt_r.state  = RT_TX;
            end else begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.state  = RT_RX;
            end
          end
        end
        RT_RX: begin
          if (scl_rise) begin
            nxt_r.shift = {r_ff.shift[6:0], sda_s};
            nxt_r.bits  = r_ff.bits + 4'h1;
          end
          if (scl_fall && r_ff.bits == 4'h8) begin
            nxt_r.sda_oe = 1'b1;
            nxt_r.state  = RT_RX_ACK;
            if (!r_ff.got_offset) begin
              nxt_r.ptr        = r_ff.shift;
              nxt_r.got_offset = 1'b1;
            end else begin
              nxt_r.ptr = r_ff.ptr + 8'h01;
              case (r_ff.ptr)
                rti_pkg::OFS_GENERAL_CONTROL:
                  nxt_r.gen_ctrl = r_ff.shift & rti_pkg::GC_WRITE_MASK;
                rti_pkg::OFS_LANE1_TX_SHAPING:   nxt_r.lane1   = r_ff.shift;
                rti_pkg::OFS_LANE2_TX_SHAPING:   nxt_r.lane2   = r_ff.shift;
                rti_pkg::OFS_ADAPTIVE_EQ_CTRL_A: nxt_r.aeq_a   = r_ff.shift;
                rti_pkg::OFS_ADAPTIVE_EQ_CTRL_B: nxt_r.aeq_b   = r_ff.shift;
                rti_pkg::OFS_CONNECTOR_RX_EQ:    nxt_r.conn_eq = r_ff.shift;
                rti_pkg::OFS_SYSTEM_RX_EQ:       nxt_r.sys_eq  = r_ff.shift;
                rti_pkg::OFS_OUTPUT_SWING_CTRL:  nxt_r.swing   = r_ff.shift;
                default: nxt_r.swing = r_ff.swing; // Unmapped writes dropped
              endcase
            end
          end
        end
        RT_TX: begin
          if (scl_rise) begin
            nxt_r.bits = r_ff.bits + 4'h1;
          end
          if (scl_fall) begin
            if (r_ff.bits == 4'h8) begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.ptr    = r_ff.ptr + 8'h01;
              nxt_r.state  = RT_TX_ACK;
            end else begin
              nxt_r.shift  = {r_ff.shift[6:0], 1'b0};
              nxt_r.sda_oe = ~r_ff.shift[6];
            end
          end
        end
        RT_TX_ACK: begin
          if (scl_rise) begin
            // Low means ack: keep sending; high means nack: stop driving
            nxt_r.state = sda_s ? RT_WAIT_STOP : RT_ADDR_ACK;
          end
        end
        RT_WAIT_STOP: nxt_r.sda_oe = 1'b0;
        RT_IDLE:      nxt_r.sda_oe = 1'b0;
        default:      nxt_r.state  = RT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      r_ff          <= '0;
      r_ff.state    <= RT_IDLE;
      r_ff.scl_sy   <= 3'h7;
      r_ff.sda_sy   <= 3'h7;
      r_ff.scl_q    <= 1'b1;
      r_ff.sda_q    <= 1'b1;
      r_ff.ptr      <= rti_pkg::RST_POINTER;
      r_ff.my_addr  <= rti_pkg::ADDR_BASE_0;
      r_ff.gen_ctrl <= rti_pkg::RST_GENERAL_CONTROL;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================
  // Outputs straight from the state flops
  assign LINK.sda_oe_dev        = r_ff.sda_oe;
  assign LIMITED_REDRIVE_SELECT = r_ff.gen_ctrl[rti_pkg::GC_LIMITED_BIT];
  assign REGISTER_EQ_SOURCE     = r_ff.gen_ctrl[rti_pkg::GC_EQ_SRC_BIT];
  assign FLIP_SELECT            = r_ff.gen_ctrl[rti_pkg::GC_FLIP_BIT];
  assign PATH_ENABLE            = r_ff.gen_ctrl[rti_pkg::GC_PATH_LSB];
  assign LANE1_TX_SHAPING       = r_ff.lane1;
  assign LANE2_TX_SHAPING       = r_ff.lane2;
  assign ADAPTIVE_EQ_CTRL_A     = r_ff.aeq_a;
  assign ADAPTIVE_EQ_CTRL_B     = r_ff.aeq_b;
  assign CONNECTOR_RX_EQ        = r_ff.conn_eq;
  assign SYSTEM_RX_EQ           = r_ff.sys_eq;
  assign OUTPUT_SWING           = r_ff.swing;
endmodule : rti_target
`default_nettype wire

// File: rtl/rti_pkg.sv
/*
  Shared constants for the two-wire register access link: the register
  map of the target, strap address table, timing and reset values.
  Assumes both ends run on one 100 MHz system clock.
*/
package rti_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_GENERAL_CONTROL    = 8'h0A;
  localparam logic [7:0] OFS_LANE1_TX_SHAPING   = 8'h0B;
  localparam logic [7:0] OFS_LANE2_TX_SHAPING   = 8'h0C;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_CTRL_A = 8'h1C;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_CTRL_B = 8'h1D;
  localparam logic [7:0] OFS_CONNECTOR_RX_EQ    = 8'h20;
  localparam logic [7:0] OFS_SYSTEM_RX_EQ       = 8'h21;
  localparam logic [7:0] OFS_OUTPUT_SWING_CTRL  = 8'h32;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_GENERAL_CONTROL    = 8'h00;
  localparam logic [7:0] RST_OTHER_REGS         = 8'h00;
  localparam logic [7:0] RST_POINTER            = 8'h00;
  // ==========================================================
  // General control field positions
  localparam int GC_LIMITED_BIT = 7;
  localparam int GC_EQ_SRC_BIT  = 4;
  localparam int GC_FLIP_BIT    = 2;
  localparam int GC_PATH_LSB    = 0;
  localparam logic [7:0] GC_WRITE_MASK = 8'h97;
  // ==========================================================
  // Strap levels and address bases
  localparam logic [1:0] STRAP_LOW   = 2'h0;
  localparam logic [1:0] STRAP_RES   = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam logic [1:0] STRAP_HIGH  = 2'h3;
  localparam logic [6:0] ADDR_BASE_0 = 7'h44;
  localparam logic [6:0] ADDR_BASE_R = 7'h20;
  localparam logic [6:0] ADDR_BASE_F = 7'h10;
  localparam logic [6:0] ADDR_BASE_1 = 7'h0C;
  // ==========================================================
  // Timing: one sequencer step, a quarter of a serial bit (1 MHz bits)
  // Fast bits keep whole register sequences short in simulation
  localparam int SYS_CLK_MHZ   = 100;
  localparam int HALF_BIT_NS   = 250;
  localparam int HALF_BIT_CYC  = (HALF_BIT_NS * SYS_CLK_MHZ) / 1000;
  localparam int SYNC_STAGES   = 3;
  // ==========================================================
  // Host command codes
  localparam logic [1:0] CMD_WRITE    = 2'h0;
  localparam logic [1:0] CMD_SET_PTR  = 2'h1;
  localparam logic [1:0] CMD_READ_AT  = 2'h2;
  localparam logic [1:0] CMD_READ_CUR = 2'h3;
  // Host APB register offsets
  localparam logic [11:0] HOFS_CTRL   = 12'h000;
  localparam logic [11:0] HOFS_DATA   = 12'h004;
  localparam logic [11:0] HOFS_STATUS = 12'h008;
  localparam logic [11:0] HOFS_RDATA  = 12'h00C;
  localparam logic [11:0] HOFS_STRAP  = 12'h010;
endpackage : rti_pkg

// File: rtl/rti_link_if.sv
/*
  Two-wire link carrier between target and controller.
  Resolves the open-drain data wire from both output enables, the clock from the controller's; undriven
  lines float high through the pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
interface rti_link_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  // Wired-AND with pull-up
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport target (input scl, input sda, output sda_oe_dev);
  modport controller (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface : rti_link_if
`default_nettype wire

// File: rtl/rti_controller.sv
/*
  Two-wire controller driven by software over APB. Runs one transaction
  per command: write, set pointer, combined read or plain read.
  Assumes the target on the link and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rti_controller (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  rti_link_if.controller   LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  // ==========================================================
  // State
  typedef enum logic [2:0] {
    RC_IDLE, RC_START, RC_BIT, RC_ACK, RC_RESTART, RC_STOP
  } rti_cstate_t;

  typedef struct packed {
    rti_cstate_t state;
    logic [7:0]  cnt;
    logic [1:0]  phase;
    logic [3:0]  bitn;
    logic [7:0]  shift;
    logic [1:0]  stage;      // 0 address, 1 offset, 2 data, 3 read addr
    logic [1:0]  cmd;
    logic [6:0]  addr;
    logic [7:0]  ofs;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        busy;
    logic        nack;
    logic        scl_oe;
    logic        sda_oe;
    logic        rx;
    logic [31:0] prdata;
    logic        pready;
  } rti_cregs_t;

  rti_cregs_t r_ff;
  rti_cregs_t nxt_r;
  logic       tick;

  assign tick = (r_ff.cnt == 8'(rti_pkg::HALF_BIT_CYC - 1));

  // ==========================================================
  // Bus slave and link sequencer
  always_comb begin
    nxt_r        = r_ff;
    nxt_r.pready = 1'b0;
    nxt_r.cnt    = tick ? 8'h00 : r_ff.cnt + 8'h01;
    // One wait state per access; data returned with pready
    if (PSEL && PENABLE && !r_ff.pready) begin
      nxt_r.pready = 1'b1;
      nxt_r.prdata = 32'h0000_0000;
      if (PWRITE) begin
        if (PADDR == rti_pkg::HOFS_DATA) begin
          nxt_r.ofs   = PWDATA[7:0];
          nxt_r.wdata = PWDATA[15:8];
        end
        if (PADDR == rti_pkg::HOFS_STRAP) nxt_r.addr = PWDATA[6:0];
        if (PADDR == rti_pkg::HOFS_CTRL && !r_ff.busy) begin
          nxt_r.cmd   = PWDATA[1:0];
          nxt_r.busy  = 1'b1;
          nxt_r.nack  = 1'b0;
          nxt_r.state = RC_START;
          nxt_r.phase = 2'h0;
          nxt_r.stage = (PWDATA[1:0] == rti_pkg::CMD_READ_CUR) ? 2'h3 : 2'h0;
        end
      end else begin
        case (PADDR)
          rti_pkg::HOFS_STATUS: nxt_r.prdata = {30'h0000_0000, r_ff.nack, r_ff.busy};
          rti_pkg::HOFS_RDATA:  nxt_r.prdata = {24'h00_0000, r_ff.rdata};
          rti_pkg::HOFS_DATA:   nxt_r.prdata = {16'h0000, r_ff.wdata, r_ff.ofs};
          rti_pkg::HOFS_STRAP:  nxt_r.prdata = {25'h000_0000, r_ff.addr};
          default:              nxt_r.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (tick) begin
      nxt_r.phase = r_ff.phase + 2'h1;
      case (r_ff.state)
        RC_START, RC_RESTART: begin
          // Phases: release both, pull data, pull clock, go
          case (r_ff.phase)
            2'h0: begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.scl_oe = 1'b0;
            end
            2'h1: nxt_r.sda_oe = 1'b1;
            2'h2: nxt_r.scl_oe = 1'b1;
            default: begin
              nxt_r.state = RC_BIT;
              nxt_r.bitn  = 4'h0;
              nxt_r.phase = 2'h0;
              nxt_r.rx    = 1'b0;
              nxt_r.shift = {r_ff.addr, r_ff.stage == 2'h3};
            end
          endcase
        end
        RC_BIT, RC_ACK: begin
          case (r_ff.phase)
            2'h0: nxt_r.sda_oe = r_ff.state == RC_ACK ? r_ff.rx && !r_ff.bitn[0]
                                                      : !r_ff.rx && !r_ff.shift[7];
            2'h1: nxt_r.scl_oe = 1'b0;
            2'h2: if (r_ff.state == RC_BIT) begin
              nxt_r.shift = {r_ff.shift[6:0], LINK.sda};
            end else if (!r_ff.rx && LINK.sda) begin
              nxt_r.nack = 1'b1;
            end
            default: begin
              nxt_r.scl_oe = 1'b1;
              nxt_r.phase  = 2'h0;
              if (r_ff.state == RC_BIT) begin
                nxt_r.bitn = r_ff.bitn + 4'h1;
                if (r_ff.bitn == 4'h7) begin
                  nxt_r.state = RC_ACK;
                  // Only one byte read per command: nack it as the last
                  nxt_r.bitn = 4'h1;
                  if (r_ff.rx) nxt_r.rdata = r_ff.shift;
                end
              end else if (r_ff.nack || r_ff.rx) begin
                nxt_r.state = RC_STOP;
              end else begin
                nxt_r.state = RC_BIT;
                nxt_r.bitn  = 4'h0;
                case (r_ff.stage)
                  2'h0: begin
                    nxt_r.stage = 2'h1;
                    nxt_r.shift = r_ff.ofs;
                  end
                  2'h1: begin
                    if (r_ff.cmd == rti_pkg::CMD_WRITE) begin
                      nxt_r.stage = 2'h2;
                      nxt_r.shift = r_ff.wdata;
                    end else if (r_ff.cmd == rti_pkg::CMD_READ_AT) begin
                      nxt_r.stage = 2'h3;
                      nxt_r.state = RC_RESTART;
                    end else begin
                      nxt_r.state = RC_STOP;
                    end
                  end
                  2'h3: begin
                    nxt_r.rx    = 1'b1;
                    nxt_r.shift = 8'hFF;
                  end
                  default: nxt_r.state = RC_STOP;
                endcase
              end
            end
          endcase
        end
        RC_STOP: begin
          // Clock low with data low, clock up, then data up
          case (r_ff.phase)
            2'h0: nxt_r.sda_oe = 1'b1;
            2'h1: nxt_r.scl_oe = 1'b0;
            2'h2: nxt_r.sda_oe = 1'b0;
            default: begin
              nxt_r.state = RC_IDLE;
              nxt_r.busy  = 1'b0;
            end
          endcase
        end
        RC_IDLE: begin
          nxt_r.scl_oe = 1'b0;
          nxt_r.sda_oe = 1'b0;
          nxt_r.phase  = 2'h0;
        end
        default: nxt_r.state = RC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      r_ff       <= '0;
      r_ff.state <= RC_IDLE;
      r_ff.addr  <= rti_pkg::ADDR_BASE_0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign LINK.scl_oe_host = r_ff.scl_oe;
  assign LINK.sda_oe_host = r_ff.sda_oe;
  assign PRDATA           = r_ff.prdata;
  assign PREADY           = r_ff.pready;
  assign PSLVERR          = 1'b0;
endmodule : rti_controller
`default_nettype wire

// File: sim/rti_link_checker.sv
/*
  Checker on the two-wire link between target and controller.
  Assumes the testbench top instantiates it beside the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module rti_link_checker (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev
);
  // ==========================================================
  // Helper logic
  // Ack plus a byte of zeros is nine bits, 36 steps, held without a break
  localparam int DRV_MAX = 40 * rti_pkg::HALF_BIT_CYC;
  logic [15:0] drv_cnt_ff;
  // Length of the current stretch of target drive
  always_ff @(posedge SYS_CLK) begin
    if (RST || !sda_oe_dev) drv_cnt_ff <= 16'h0000;
    else drv_cnt_ff <= drv_cnt_ff + 16'h0001;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_lines_reset_free: assert property ($fell(RST) |-> !sda_oe_dev && !scl_oe_host && !sda_oe_host)
    else $error("link lines held after reset");
  a_dev_change_low: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("target moved data while clock high");
  a_dev_high_hold: assert property ($rose(scl) |-> $stable(sda_oe_dev)[*8])
    else $error("target data unstable after clock rise");
  a_dev_start_quiet: assert property (scl && $fell(sda) |-> ##1 !sda_oe_dev[*8])
    else $error("target drives during address");
  a_dev_stop_quiet: assert property (scl && $rose(sda) |-> !sda_oe_dev[*8])
    else $error("target drives after stop");
  a_host_frame_free: assert property ($changed(sda_oe_host) && scl |-> !sda_oe_dev)
    else $error("target holds data at start or stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low phase too short");
  a_dev_drive_bound: assert property (drv_cnt_ff < DRV_MAX)
    else $error("target holds data line too long");
endmodule : rti_link_checker
`default_nettype wire

// File: sim/i2c_target_register_access_tb_top.sv
/*
  Testbench: controller and target joined by the link, driven over APB.
  Assumes the rtl package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_target_register_access_tb_top;
  // ==========================================================
  // Signals
  logic        SYS_CLK = 1'b0;
  logic        RST     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd, st;
  logic        pready, lim, eqs, flip, path;
  logic [1:0]  up_s, lo_s;
  logic [7:0]  lane1, gv, rv;
  logic [7:0]  lane2, aeq_a, aeq_b, conn_eq, sys_eq, swing;
  logic [6:0]  addr;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          seed = 98727;
  // Clock
  always #5 SYS_CLK = ~SYS_CLK;
  // ==========================================================
  // Design under test
  rti_link_if rti_link_if_i ();
  rti_target rti_target_i (.SYS_CLK(SYS_CLK), .RST(RST), .LINK(rti_link_if_i),
    .UPPER_ADDRESS_STRAP(up_s), .LOWER_ADDRESS_STRAP(lo_s), .LIMITED_REDRIVE_SELECT(lim),
    .REGISTER_EQ_SOURCE(eqs), .FLIP_SELECT(flip), .PATH_ENABLE(path), .LANE1_TX_SHAPING(lane1),
    .LANE2_TX_SHAPING(lane2), .ADAPTIVE_EQ_CTRL_A(aeq_a), .ADAPTIVE_EQ_CTRL_B(aeq_b),
    .CONNECTOR_RX_EQ(conn_eq), .SYSTEM_RX_EQ(sys_eq), .OUTPUT_SWING(swing));
  rti_controller rti_controller_i (.SYS_CLK(SYS_CLK), .RST(RST), .LINK(rti_link_if_i),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR());
  rti_link_checker rti_link_checker_i (.SYS_CLK(SYS_CLK), .RST(RST),
    .scl(rti_link_if_i.scl), .sda(rti_link_if_i.sda), .scl_oe_host(rti_link_if_i.scl_oe_host),
    .sda_oe_host(rti_link_if_i.sda_oe_host), .sda_oe_dev(rti_link_if_i.sda_oe_dev));
  // ==========================================================
  // Tasks and functions
  function automatic logic [6:0] addr_of(input logic [1:0] u, input logic [1:0] l);
    logic [6:0] b;
    case (u)
      2'h0: b = rti_pkg::ADDR_BASE_0;
      2'h1: b = rti_pkg::ADDR_BASE_R;
      2'h2: b = rti_pkg::ADDR_BASE_F;
      default: b = rti_pkg::ADDR_BASE_1;
    endcase
    return b + 7'(l);
  endfunction : addr_of
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; request held until PREADY is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge SYS_CLK);
    penable <= 1'b1;
    do @(posedge SYS_CLK); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Command, wait for idle, then status in st and read byte in rd
  task automatic xfer(input logic [1:0] c, input logic [7:0] o, input logic [7:0] v);
    int n;
    n = 0;
    apb(1'b1, rti_pkg::HOFS_DATA, {16'h0, v, o});
    apb(1'b1, rti_pkg::HOFS_CTRL, {30'h0, c});
    do begin
      apb(1'b0, rti_pkg::HOFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 5000);
    if (n >= 5000) n_errors++;
    st = rd;
    apb(1'b0, rti_pkg::HOFS_RDATA, 32'h0);
  endtask : xfer
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // Main sequence
  initial begin
    up_s = 2'($random(seed));
    lo_s = 2'($random(seed));
    addr = addr_of(up_s, lo_s);
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    apb(1'b0, rti_pkg::HOFS_STRAP, 32'h0);
    chk(rd[7:0], 8'h44);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd[7:0], 8'h00);
    chk({lim, eqs, flip, path, 4'h0}, 8'h00);
    // Neighbour address in the same group must be refused
    apb(1'b1, rti_pkg::HOFS_STRAP, {25'h0, addr ^ 7'h01});
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_LANE1_TX_SHAPING, 8'h5A);
    chk(8'(st[1]), 8'h01);
    chk(lane1, 8'h00);
    apb(1'b1, rti_pkg::HOFS_STRAP, {25'h0, addr});
    // Orientation value drawn from the three allowed settings
    case ($unsigned($random(seed)) % 3)
      0: gv = 8'h91;
      1: gv = 8'h95;
      default: gv = 8'h90;
    endcase
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_GENERAL_CONTROL, gv);
    chk(8'(st[1]), 8'h00);
    chk({lim, eqs, flip, path, 4'h0}, {gv[7], gv[4], gv[2], gv[0], 4'h0});
    rv = 8'($random(seed));
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_LANE1_TX_SHAPING, rv);
    chk(lane1, rv);
    xfer(rti_pkg::CMD_READ_AT, rti_pkg::OFS_GENERAL_CONTROL, 8'h00);
    chk(rd[7:0], gv);
    xfer(rti_pkg::CMD_READ_CUR, 8'h00, 8'h00);
    chk(rd[7:0], rv);
    xfer(rti_pkg::CMD_SET_PTR, rti_pkg::OFS_LANE1_TX_SHAPING, 8'h00);
    chk(lane1, rv);
    chk({lim, eqs, flip, path, 4'h0}, {gv[7], gv[4], gv[2], gv[0], 4'h0});
    xfer(rti_pkg::CMD_READ_CUR, 8'h00, 8'h00);
    chk(rd[7:0], rv);
    // Power-on table for adaptive limited mode
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_LANE2_TX_SHAPING, 8'h6C);
    chk(lane2, 8'h6C);
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_OUTPUT_SWING_CTRL, 8'hC0);
    chk(swing, 8'hC0);
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_ADAPTIVE_EQ_CTRL_B, 8'h10);
    chk(aeq_b, 8'h10);
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_ADAPTIVE_EQ_CTRL_A, 8'h85);
    chk(aeq_a, 8'h85);
    // Pointer has moved past the byte just written
    xfer(rti_pkg::CMD_READ_CUR, 8'h00, 8'h00);
    chk(rd[7:0], 8'h10);
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_CONNECTOR_RX_EQ, 8'h11);
    chk(conn_eq, 8'h11);
    xfer(rti_pkg::CMD_WRITE, rti_pkg::OFS_SYSTEM_RX_EQ, 8'h55);
    chk(sys_eq, 8'h55);
    final_report();
  end
  // Watchdog: the sequence needs about 40k cycles
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    n_errors++;
    final_report();
  end
endmodule : i2c_target_register_access_tb_top
`default_nettype wire
